/* File: hw/thp_pkg.sv */
/*
  Shared constants for the thermal printer interface: timing counts, control
  latch bit positions, transaction codes and the controller's register map.
  Assumes a single 20 MHz clock shared by both ends.
*/
package thp_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int ALE_HZ = 400_000;
  localparam int ALE_DIV = CLK_HZ / ALE_HZ;
  localparam int DOE_MAX_US = 2400;
  localparam int DOE_MAX_CYC = DOE_MAX_US * (CLK_HZ / 1_000_000);
  localparam int DOE_WIDTH_US = 2000;
  localparam int DOE_WIDTH_CYC = DOE_WIDTH_US * (CLK_HZ / 1_000_000);
  localparam int HOLD_US = 100;
  localparam int HOLD_CYC = HOLD_US * (CLK_HZ / 1_000_000);
  localparam int ACK_CYC = 2;

  // ****************************************************************
  // Print geometry
  // ****************************************************************
  localparam int COLS = 40;
  localparam int SHIFT_PULSES = COLS + 1;
  localparam int SLOTS = 7;
  localparam int ROWS = 7;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_I = 8'h49;

  // ****************************************************************
  // Control latch bits
  // ****************************************************************
  localparam logic [2:0] LB_STROBE = 3'h0;
  localparam logic [2:0] LB_START = 3'h1;
  localparam logic [2:0] LB_KILL = 3'h2;
  localparam logic [2:0] LB_TAKEUP = 3'h3;
  localparam logic [2:0] LB_PRINTER_POWER_REQ = 3'h4;
  localparam logic [2:0] LB_RDSTB_N = 3'h5;
  localparam logic [2:0] LB_BUSY = 3'h6;
  localparam logic [7:0] LATCH_RST = 8'h20;

  // ****************************************************************
  // Bus transaction types {iface_ctrl_b, iface_ctrl_a}
  // ****************************************************************
  localparam logic [1:0] TT_DATA = 2'h0;
  localparam logic [1:0] TT_ACK = 2'h1;

  // ****************************************************************
  // Controller register map
  // ****************************************************************
  localparam logic [1:0] HR_DATA = 2'h0;
  localparam logic [1:0] HR_CTRL = 2'h1;
  localparam logic [1:0] HR_STAT = 2'h2;
  localparam int HC_ACK = 0;
  localparam int HC_CART = 1;

endpackage : thp_pkg

/* File: hw/thp_bus_if.sv */
/*
  Internal parallel bus between the system controller and the printer
  interface, plus the power arbitration lines to the cartridge board.
  Assumes both ends share one clock; undriven shared lines read high.
*/
interface thp_bus_if;
  logic [7:0] bus_data;
  logic board_select_a_n;
  logic board_select_b_n;
  logic iface_ctrl_a;
  logic iface_ctrl_b;
  logic host_data_ready;
  logic busy_drv;
  logic busy_oe;
  logic rdstb_drv;
  logic rdstb_oe;
  logic busy;
  logic read_strobe_n;
  logic printer_irq_n;
  logic printer_power_req;
  logic cartridge_power_req;

  // The shared lines are pulled high while the printer leaves them floating.
  assign busy = busy_oe ? busy_drv : 1'b1;
  assign read_strobe_n = rdstb_oe ? rdstb_drv : 1'b1;

  modport dev (
    input bus_data, board_select_a_n, board_select_b_n, iface_ctrl_a,
    input iface_ctrl_b, host_data_ready, cartridge_power_req,
    output busy_drv, busy_oe, rdstb_drv, rdstb_oe, printer_irq_n,
    output printer_power_req
  );

  modport host (
    output bus_data, board_select_a_n, board_select_b_n, iface_ctrl_a,
    output iface_ctrl_b, host_data_ready, cartridge_power_req,
    input busy, read_strobe_n, printer_irq_n, printer_power_req
  );
endinterface : thp_bus_if

/* File: hw/thp_ctrl_latch.sv */
/*
  Eight-bit addressable control latch: each write pulse changes one output.
  Assumes the caller issues at most one write per clock.
*/
module thp_ctrl_latch
  import thp_pkg::*;
#(
  parameter logic [7:0] RST_VAL = LATCH_RST
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [2:0] sel_i,
  input wire logic val_i,
  output logic [7:0] q_o
);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q_o <= RST_VAL;
    end
    else if (wr_i)
    begin
      q_o[sel_i] <= val_i;
    end
  end

endmodule : thp_ctrl_latch

/* File: hw/thp_printer_dev.sv */
/*
  Printer interface end: receives lines from the controller, arbitrates
  supply power with the cartridge board and drives the thermal mechanism.
  Assumes all inputs are synchronous to clk_i.
*/
module thp_printer_dev
  import thp_pkg::*;
#(
  parameter int DOE_WIDTH = DOE_WIDTH_CYC,
  parameter int DOE_MAX = DOE_MAX_CYC,
  parameter int HOLD = HOLD_CYC
)(
  input wire logic clk_i,
  input wire logic rst_i,
  thp_bus_if.dev bus,
  input wire logic head_right_end_i,
  input wire logic dot_phase_a_i,
  input wire logic dot_phase_b_i,
  input wire logic paper_end_n_i,
  input wire logic panel_switch_a_n_i,
  input wire logic panel_switch_b_n_i,
  input wire logic printer_on_i,
  input wire logic selftest_input_n_i,
  input wire logic holdoff_bypass_i,
  output logic dot_data_o,
  output logic dot_shift_clock_o,
  output logic dot_load_strobe_o,
  output logic dot_output_enable_o,
  output logic doe_started_n_o,
  output logic phase_state_o,
  output logic print_motor_on_o,
  output logic takeup_motor_on_o
);

  typedef enum logic [4:0] {
    D_IDLE, D_STB_LO, D_STB_HI, D_BUSY_LO, D_ARB, D_ARB_GAP, D_ARB_CHK,
    D_SWEEP, D_SHIFT, D_LD_HI, D_LD_LO, D_SLOT, D_FIRE, D_DOE, D_KILL,
    D_NEXT, D_END, D_PAPER
  } thp_dstate_t;

  // Dot for one column, row and slot; rows 0 and 6 are blank except for I.
  function automatic logic glyph(input logic [7:0] ch, input logic [2:0] row,
                                 input logic [2:0] slot);
    if (ch == CH_I)
      glyph = (row == 3'h0 || row == 3'h6) ? (slot != 3'h0 && slot != 3'h6)
                                           : (slot == 3'h3);
    else
      glyph = (row != 3'h0 && row != 3'h6) && ch[slot];
  endfunction : glyph

  thp_dstate_t st_q;
  logic [7:0] line_q [COLS];
  logic [7:0] cap_q;
  logic [5:0] len_q, idx_q, cols_q;
  logic [2:0] row_q, slot_q;
  logic ph_q, blank_q, st_line_q, selftest_q, paper_irq_q, byte_irq_q;
  logic [4:0] sw1_q, sw2_q;
  logic [5:0] ale_q;
  logic [2:0] smp_q, deb_q, deb_prev_q;
  logic start_prev_q, busy_prev_q, hold_q, irq_n_q, sel_q, st_prev_q;
  logic [15:0] hold_cnt_q, on_cnt_q;
  logic lw;
  logic [2:0] lsel;
  logic lval;
  logic [7:0] lq;
  logic sel, paper_out, takeup_want, advance, prn_on, st_press, tick;
  logic [2:0] head_raw;
  logic slot_ev, re_rise, doe_busy, line_done;
  logic [7:0] cur_ch;

  // ****************************************************************
  // Input conditioning
  // ****************************************************************
  assign sel = !bus.board_select_a_n && !bus.board_select_b_n;
  assign paper_out = !sw2_q[0];
  assign takeup_want = sw2_q[1];
  assign advance = !sw2_q[2];
  assign prn_on = sw2_q[3];
  assign st_press = !sw2_q[4] && st_prev_q;
  assign head_raw = {dot_phase_b_i, dot_phase_a_i, head_right_end_i};
  assign tick = ale_q == 6'(ALE_DIV - 1);
  assign re_rise = deb_q[0] && !deb_prev_q[0];
  assign slot_ev = (deb_q[1] && !deb_prev_q[1]) || (deb_q[2] && !deb_prev_q[2]);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sw1_q <= 5'h1f;
      sw2_q <= 5'h1f;
      st_prev_q <= 1'b1;
    end
    else
    begin
      st_prev_q <= sw2_q[4];
      sw1_q <= {selftest_input_n_i, printer_on_i, panel_switch_b_n_i,
                panel_switch_a_n_i, paper_end_n_i};
      sw2_q <= sw1_q;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ale_q <= 6'h00;
      smp_q <= 3'h0;
      deb_q <= 3'h0;
      deb_prev_q <= 3'h0;
      phase_state_o <= 1'b0;
    end
    else
    begin
      ale_q <= tick ? 6'h00 : ale_q + 6'h01;
      deb_prev_q <= deb_q;
      if (tick)
      begin
        smp_q <= head_raw;
        deb_q <= (smp_q & head_raw) | (deb_q & (smp_q | head_raw));
      end
      if (deb_q[1] && !deb_q[2])
        phase_state_o <= 1'b1;
      else if (deb_q[2] && !deb_q[1])
        phase_state_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Control latch and its write arbitration
  // ****************************************************************
  always_comb
  begin
    lw = 1'b0;
    lsel = LB_TAKEUP;
    lval = 1'b0;
    unique case (st_q)
      D_IDLE:
      begin
        lsel = (paper_out || (sel && bus.host_data_ready && !bus.iface_ctrl_a))
               ? LB_BUSY : LB_TAKEUP;
        lval = (lsel == LB_BUSY) ? 1'b1 : takeup_want;
        lw = (lsel == LB_BUSY) || (lq[LB_TAKEUP] != takeup_want);
      end
      D_STB_LO: begin lw = 1'b1; lsel = LB_RDSTB_N; lval = 1'b0; end
      D_STB_HI: begin lw = 1'b1; lsel = LB_RDSTB_N; lval = 1'b1; end
      D_BUSY_LO: begin lw = 1'b1; lsel = LB_BUSY; lval = 1'b0; end
      D_ARB: begin lw = !bus.cartridge_power_req; lsel = LB_PRINTER_POWER_REQ; lval = 1'b1; end
      D_ARB_CHK: begin lw = bus.cartridge_power_req; lsel = LB_PRINTER_POWER_REQ; end
      D_LD_HI: begin lw = 1'b1; lsel = LB_STROBE; lval = 1'b1; end
      D_LD_LO: begin lw = 1'b1; lsel = LB_STROBE; end
      D_SLOT: begin lw = slot_ev && !blank_q; lsel = LB_START; lval = 1'b1; end
      D_FIRE: begin lw = 1'b1; lsel = LB_START; end
      D_DOE:
      begin
        lw = dot_output_enable_o && on_cnt_q == 16'(DOE_MAX - 2);
        lsel = LB_KILL;
        lval = 1'b1;
      end
      D_KILL: begin lw = 1'b1; lsel = LB_KILL; end
      D_END: begin lw = 1'b1; lsel = LB_PRINTER_POWER_REQ; end
      D_PAPER: begin lw = !paper_out; lsel = LB_BUSY; end
      default: begin lw = lq[LB_TAKEUP] != takeup_want; lval = takeup_want; end
    endcase
  end

  thp_ctrl_latch u_latch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(lw),
    .sel_i(lsel),
    .val_i(lval),
    .q_o(lq)
  );

  assign dot_load_strobe_o = lq[LB_STROBE];
  assign takeup_motor_on_o = lq[LB_TAKEUP];
  assign bus.printer_power_req = lq[LB_PRINTER_POWER_REQ];
  assign bus.busy_drv = lq[LB_BUSY];
  assign bus.rdstb_drv = lq[LB_RDSTB_N];
  assign bus.busy_oe = sel_q;
  assign bus.rdstb_oe = sel_q;
  assign bus.printer_irq_n = irq_n_q;

  // ****************************************************************
  // Bus indications and interrupt
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sel_q <= 1'b0;
      busy_prev_q <= 1'b0;
      byte_irq_q <= 1'b0;
      irq_n_q <= 1'b1;
    end
    else
    begin
      sel_q <= sel;
      busy_prev_q <= lq[LB_BUSY];
      byte_irq_q <= (busy_prev_q && !lq[LB_BUSY]) || (byte_irq_q && !sel);
      irq_n_q <= !(byte_irq_q || paper_irq_q);
    end
  end

  // ****************************************************************
  // Output enable timers
  // ****************************************************************
  assign doe_busy = hold_q || dot_output_enable_o;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      start_prev_q <= 1'b0;
      hold_q <= 1'b0;
      hold_cnt_q <= 16'h0000;
      on_cnt_q <= 16'h0000;
      dot_output_enable_o <= 1'b0;
      doe_started_n_o <= 1'b1;
    end
    else
    begin
      start_prev_q <= lq[LB_START];
      if (lq[LB_KILL])
      begin
        hold_q <= 1'b0;
        dot_output_enable_o <= 1'b0;
        doe_started_n_o <= 1'b1;
      end
      else if (lq[LB_START] && !start_prev_q)
      begin
        hold_q <= !holdoff_bypass_i;
        hold_cnt_q <= 16'h0000;
        on_cnt_q <= 16'h0000;
        dot_output_enable_o <= holdoff_bypass_i;
        doe_started_n_o <= !holdoff_bypass_i;
      end
      else if (hold_q)
      begin
        hold_cnt_q <= hold_cnt_q + 16'h0001;
        if (hold_cnt_q == 16'(HOLD - 1))
        begin
          hold_q <= 1'b0;
          dot_output_enable_o <= 1'b1;
          doe_started_n_o <= 1'b0;
        end
      end
      else if (dot_output_enable_o)
      begin
        on_cnt_q <= on_cnt_q + 16'h0001;
        if (on_cnt_q == 16'(DOE_WIDTH - 1))
        begin
          dot_output_enable_o <= 1'b0;
          doe_started_n_o <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Line sequencer
  // ****************************************************************
  assign line_done = cap_q == CH_CR || len_q == 6'(COLS - 1);
  assign cur_ch = st_line_q ? CH_I : line_q[6'(COLS - 1) - idx_q];

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q <= D_IDLE;
      cap_q <= 8'h00;
      len_q <= 6'h00;
      cols_q <= 6'h00;
      idx_q <= 6'h00;
      row_q <= 3'h0;
      slot_q <= 3'h0;
      ph_q <= 1'b0;
      blank_q <= 1'b0;
      st_line_q <= 1'b0;
      selftest_q <= 1'b0;
      paper_irq_q <= 1'b0;
      dot_data_o <= 1'b0;
      dot_shift_clock_o <= 1'b0;
      print_motor_on_o <= 1'b0;
    end
    else
    begin
      if (st_press)
        selftest_q <= !selftest_q;
      dot_shift_clock_o <= 1'b0;
      unique case (st_q)
        D_IDLE:
          if (paper_out)
          begin
            paper_irq_q <= 1'b1;
            len_q <= 6'h00;
            st_q <= D_PAPER;
          end
          else if (sel && bus.host_data_ready && !bus.iface_ctrl_a)
          begin
            cap_q <= bus.bus_data;
            st_q <= D_STB_LO;
          end
          else if ((selftest_q && prn_on) || advance)
          begin
            st_line_q <= selftest_q && prn_on;
            blank_q <= !(selftest_q && prn_on);
            st_q <= D_ARB;
          end
        D_STB_LO: st_q <= D_STB_HI;
        D_STB_HI:
        begin
          if (cap_q != CH_CR)
            line_q[len_q] <= cap_q;
          len_q <= line_done ? 6'h00 : len_q + 6'h01;
          // Columns past the end of a short line print blank, not stale bytes.
          if (line_done)
            cols_q <= (cap_q == CH_CR) ? len_q : len_q + 6'h01;
          blank_q <= 1'b0;
          st_line_q <= 1'b0;
          st_q <= (line_done && prn_on) ? D_ARB : D_BUSY_LO;
        end
        D_BUSY_LO: st_q <= D_IDLE;
        D_ARB: if (!bus.cartridge_power_req) st_q <= D_ARB_GAP;
        D_ARB_GAP: st_q <= D_ARB_CHK;
        D_ARB_CHK:
          if (bus.cartridge_power_req)
            st_q <= D_ARB;
          else
          begin
            print_motor_on_o <= 1'b1;
            row_q <= 3'h0;
            st_q <= D_SWEEP;
          end
        D_SWEEP:
          if (re_rise)
          begin
            slot_q <= 3'h0;
            idx_q <= 6'h00;
            ph_q <= 1'b0;
            st_q <= D_SHIFT;
          end
        D_SHIFT:
          if (!ph_q)
          begin
            dot_data_o <= idx_q < 6'(COLS) && !blank_q && glyph(cur_ch, row_q, slot_q)
                          && (st_line_q || 6'(COLS - 1) - idx_q < cols_q);
            ph_q <= 1'b1;
          end
          else
          begin
            dot_shift_clock_o <= 1'b1;
            ph_q <= 1'b0;
            idx_q <= idx_q + 6'h01;
            if (idx_q == 6'(SHIFT_PULSES - 1))
              st_q <= D_LD_HI;
          end
        D_LD_HI: st_q <= D_LD_LO;
        D_LD_LO: st_q <= D_SLOT;
        D_SLOT: if (slot_ev) st_q <= blank_q ? D_NEXT : D_FIRE;
        D_FIRE: st_q <= D_DOE;
        D_DOE:
          if (dot_output_enable_o && on_cnt_q == 16'(DOE_MAX - 2))
            st_q <= D_KILL;
          else if (!doe_busy)
            st_q <= D_NEXT;
        D_KILL: st_q <= D_NEXT;
        D_NEXT:
        begin
          idx_q <= 6'h00;
          ph_q <= 1'b0;
          if (slot_q != 3'(SLOTS - 1))
          begin
            slot_q <= slot_q + 3'h1;
            st_q <= D_SHIFT;
          end
          else if (row_q != 3'(ROWS - 1))
          begin
            row_q <= row_q + 3'h1;
            st_q <= D_SWEEP;
          end
          else
            st_q <= D_END;
        end
        D_END:
        begin
          print_motor_on_o <= 1'b0;
          st_q <= lq[LB_BUSY] ? D_BUSY_LO : D_IDLE;
        end
        D_PAPER:
        begin
          if (sel && bus.iface_ctrl_a && !bus.iface_ctrl_b)
            paper_irq_q <= 1'b0;
          if (!paper_out)
          begin
            paper_irq_q <= 1'b0;
            st_q <= D_IDLE;
          end
        end
      endcase
    end
  end

endmodule : thp_printer_dev

/* File: hw/thp_host_end.sv */
/*
  System controller and cartridge board end: sends bytes to the printer,
  acknowledges paper out and requests supply power for the tape motor.
  Assumes software uses the plain register port in the same clock domain.
*/
module thp_host_end
  import thp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  thp_bus_if.host bus,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o
);

  typedef enum logic [1:0] {H_IDLE, H_WBUSY, H_WSTB, H_ACK} thp_hstate_t;

  thp_hstate_t st_q;
  logic [1:0] ack_q;
  logic sel_n_q, ready_q, cart_want_q, cart_req_q, cart_run_q;
  logic [7:0] tx_q;
  logic [1:0] tt_q;
  logic ack_wr;

  assign bus.bus_data = tx_q;
  assign bus.board_select_a_n = sel_n_q;
  assign bus.board_select_b_n = sel_n_q;
  assign bus.iface_ctrl_a = tt_q[0];
  assign bus.iface_ctrl_b = tt_q[1];
  assign bus.host_data_ready = ready_q;
  assign bus.cartridge_power_req = cart_req_q;
  assign ack_wr = wr_i && addr_i == HR_CTRL && wdata_i[HC_ACK];

  // ****************************************************************
  // Bus transactions
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q <= H_IDLE;
      sel_n_q <= 1'b1;
      ready_q <= 1'b0;
      tx_q <= 8'h00;
      tt_q <= TT_DATA;
      ack_q <= 2'h0;
    end
    else
    begin
      unique case (st_q)
        H_IDLE:
          if (ack_wr)
          begin
            sel_n_q <= 1'b0;
            tt_q <= TT_ACK;
            ack_q <= 2'h0;
            st_q <= H_ACK;
          end
          else if (wr_i && addr_i == HR_DATA)
          begin
            tx_q <= wdata_i;
            tt_q <= TT_DATA;
            sel_n_q <= 1'b0;
            st_q <= H_WBUSY;
          end
        H_WBUSY:
          if (ack_wr)
          begin
            tt_q <= TT_ACK;
            ack_q <= 2'h0;
            st_q <= H_ACK;
          end
          else if (!bus.busy)
          begin
            ready_q <= 1'b1;
            st_q <= H_WSTB;
          end
        H_WSTB:
          if (!bus.read_strobe_n)
          begin
            ready_q <= 1'b0;
            sel_n_q <= 1'b1;
            st_q <= H_IDLE;
          end
        H_ACK:
        begin
          ack_q <= ack_q + 2'h1;
          if (ack_q == 2'(ACK_CYC - 1))
          begin
            sel_n_q <= 1'b1;
            tt_q <= TT_DATA;
            st_q <= H_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Cartridge power request and register reads
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cart_want_q <= 1'b0;
      cart_req_q <= 1'b0;
      cart_run_q <= 1'b0;
      rdata_o <= 8'h00;
    end
    else
    begin
      if (wr_i && addr_i == HR_CTRL)
        cart_want_q <= wdata_i[HC_CART];
      cart_req_q <= cart_want_q;
      cart_run_q <= cart_req_q && cart_want_q && !bus.printer_power_req;
      rdata_o <= 8'h00;
      if (rd_i && addr_i == HR_STAT)
        rdata_o <= {3'h0, cart_run_q, bus.printer_power_req, !bus.printer_irq_n,
                    bus.busy, st_q != H_IDLE};
      else if (rd_i && addr_i == HR_CTRL)
        rdata_o <= {6'h00, cart_want_q, 1'b0};
      else if (rd_i && addr_i == HR_DATA)
        rdata_o <= tx_q;
    end
  end

endmodule : thp_host_end

/* File: verif/thp_bus_sva.sv */
/*
  Checker on the shared printer bus signals between the two ends.
  Assumes one clock and the pulled-up resolved busy and strobe lines.
*/
module thp_bus_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic board_select_a_n,
  input wire logic board_select_b_n,
  input wire logic iface_ctrl_a,
  input wire logic host_data_ready,
  input wire logic busy_drv,
  input wire logic busy_oe,
  input wire logic busy,
  input wire logic read_strobe_n,
  input wire logic printer_irq_n,
  input wire logic printer_power_req,
  input wire logic cartridge_power_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************
  // Bus properties
  // ********************
  logic sel;
  assign sel = !board_select_a_n && !board_select_b_n;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_sel_drive: assert property (sel [*3] |-> busy_oe)
    else $error("busy driver off while selected");
  a_sel_float: assert property (!sel [*3] |-> busy && read_strobe_n)
    else $error("bus driven while not selected");
  a_irq_busy: assert property ($fell(busy_drv) && !sel |-> ##[1:3] !printer_irq_n)
    else $error("no interrupt after busy fell");
  a_power_wait: assert property ($rose(printer_power_req) |-> !$past(cartridge_power_req))
    else $error("power request raised over cartridge");
  a_strobe_ready: assert property (!read_strobe_n |-> host_data_ready && sel)
    else $error("strobe without a byte offered");
  a_strobe_one: assert property (!read_strobe_n |=> read_strobe_n)
    else $error("strobe longer than one cycle");
  a_strobe_busy: assert property (!read_strobe_n |-> busy)
    else $error("strobe while not busy");
  a_ack_release: assert property (sel && iface_ctrl_a |-> ##[1:4] printer_irq_n)
    else $error("interrupt kept after acknowledge");
  cover property (sel && iface_ctrl_a);
  cover property ($rose(printer_power_req));
  cover property (!read_strobe_n);
endmodule : thp_bus_sva

/* File: verif/tb_top.sv */
/*
  Bench joining both ends and playing the print mechanism.
  Assumes shortened enable timings: width 40, limit 30, hold-off 5 cycles.
*/
module tb_top
  import thp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ********************
  // Stimulus and checks
  // ********************
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [2:0] mech = 3'h0;
  logic paper_n = 1'h1;
  logic swa_n = 1'h1;
  logic on = 1'h1;
  logic byp = 1'h0;
  logic [7:0] rdata, s;
  logic dsc, dls, doe, dsn, ph, pm, tm, dd;
  int ndot = 0;
  int errors = 0;
  int checked = 0;
  int nclk = 0;
  int nls = 0;
  int ndoe = 0;
  int w = 0;
  always #25 clk_i = ~clk_i;
  thp_bus_if bus();
  thp_host_end i_thp_host_end (.clk_i(clk_i), .rst_i(rst_i), .bus(bus), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
  thp_printer_dev #(.DOE_WIDTH(40), .DOE_MAX(30), .HOLD(5)) i_thp_printer_dev (.clk_i(clk_i),
    .rst_i(rst_i), .bus(bus), .head_right_end_i(mech[0]), .dot_phase_a_i(mech[1]),
    .dot_phase_b_i(mech[2]), .paper_end_n_i(paper_n), .panel_switch_a_n_i(swa_n),
    .panel_switch_b_n_i(1'h1), .printer_on_i(on), .selftest_input_n_i(1'h1),
    .holdoff_bypass_i(byp), .dot_data_o(dd), .dot_shift_clock_o(dsc), .dot_load_strobe_o(dls),
    .dot_output_enable_o(doe), .doe_started_n_o(dsn), .phase_state_o(ph),
    .print_motor_on_o(pm), .takeup_motor_on_o(tm));
  thp_bus_sva i_thp_bus_sva (.clk_i(clk_i), .rst_i(rst_i),
    .board_select_a_n(bus.board_select_a_n), .board_select_b_n(bus.board_select_b_n),
    .iface_ctrl_a(bus.iface_ctrl_a), .host_data_ready(bus.host_data_ready),
    .busy_drv(bus.busy_drv), .busy_oe(bus.busy_oe), .busy(bus.busy),
    .read_strobe_n(bus.read_strobe_n), .printer_irq_n(bus.printer_irq_n),
    .printer_power_req(bus.printer_power_req), .cartridge_power_req(bus.cartridge_power_req));
  task automatic stop_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask : chk1
  task automatic put(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk_i);
    wr <= 1'h0;
  endtask : put
  task automatic get(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk_i);
    rd <= 1'h0;
    #1 d = rdata;
  endtask : get
  task automatic send(input logic [7:0] d);
    put(HR_DATA, d);
    repeat (50)
    begin
      get(HR_STAT, s);
      if (s[0] === 1'h0)
        break;
    end
    chk1(s[0], 1'h0);
  endtask : send
  // A mechanism pulse lasts long enough to pass the debounce stage.
  task automatic pulse(input int k);
    mech <= 3'h1 << k;
    repeat (150) @(posedge clk_i);
    mech <= 3'h0;
    repeat (250) @(posedge clk_i);
  endtask : pulse
  always @(posedge clk_i)
  begin
    nclk += dsc;
    ndot += dsc && dd;
    if (dls)
    begin
      chk8(8'(nclk), 8'h29);
      nclk = 0;
      nls++;
    end
    if (doe)
    begin
      w++;
      chk1(dsn, 1'h0);
    end
    else if (w != 0)
    begin
      chk8(8'(w), 8'h1e);
      w = 0;
      ndoe++;
    end
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    swa_n <= 1'h0;
    repeat (50) @(posedge clk_i);
    chk1(tm, 1'h0);
    swa_n <= 1'h1;
    repeat (50) @(posedge clk_i);
    chk1(tm, 1'h1);
    put(HR_CTRL, 8'h02);
    send(CH_I);
    send(CH_CR);
    repeat (300) @(posedge clk_i);
    chk1(bus.printer_power_req, 1'h0);
    put(HR_CTRL, 8'h00);
    repeat (20) @(posedge clk_i);
    chk1(bus.printer_power_req, 1'h1);
    for (int r = 0; r < 7; r++)
    begin
      byp <= 1'(r == 6);
      pulse(0);
      chk1(pm, 1'h1);
      for (int j = 0; j < 7; j++)
      begin
        pulse(2 - j % 2);
        chk1(ph, 1'(j % 2));
      end
    end
    chk8(8'(nls), 8'h31);
    chk8(8'(ndoe), 8'h31);
    chk8(8'(ndot), 8'h0f);
    chk1(pm, 1'h0);
    chk1(bus.printer_irq_n, 1'h0);
    on <= 1'h0;
    send(CH_CR);
    repeat (100) @(posedge clk_i);
    chk1(bus.printer_power_req, 1'h0);
    on <= 1'h1;
    put(HR_CTRL, 8'h01);
    repeat (20) @(posedge clk_i);
    chk1(bus.printer_irq_n, 1'h1);
    paper_n <= 1'h0;
    repeat (100) @(posedge clk_i);
    chk1(bus.printer_irq_n, 1'h0);
    chk1(bus.busy_drv, 1'h1);
    put(HR_CTRL, 8'h01);
    repeat (20) @(posedge clk_i);
    chk1(bus.printer_irq_n, 1'h1);
    paper_n <= 1'h1;
    repeat (20) @(posedge clk_i);
    stop_test();
  end
  initial
  begin
    repeat (40000) @(posedge clk_i);
    errors++;
    stop_test();
  end
endmodule : tb_top
